/* hw/pio_pkg.sv */
// shared constants and types of the parallel i/o ports block
// assumes: one clock domain, apb register access, 32-bit bus data
package pio_pkg;

    // widths of the two bidirectional ports, the input-only port and the analog channel field
    localparam int PORT_W = 8;
    localparam int IN_W = 4;
    localparam int CHAN_W = 2;

    // apb widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register indexes; byte address is four times the index
    localparam logic [2:0] IDX_FIRST_DATA = 3'h0;
    localparam logic [2:0] IDX_SECOND_DATA = 3'h1;
    localparam logic [2:0] IDX_INPUT_DATA = 3'h3;
    localparam logic [2:0] IDX_FIRST_DIR = 3'h4;
    localparam logic [2:0] IDX_SECOND_DIR = 3'h5;

    // position of the index inside paddr
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 4;

    // reset values
    localparam logic DIR_RESET_BIT = 1'b0;
    localparam logic PIN_IDLE_HIGH = 1'b1;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

    // base of the one-hot analog channel decode
    localparam logic [IN_W-1:0] ONE_HOT_BASE = 4'h1;

    // build-time choice of the external interrupt sensitivity
    typedef enum {PIO_EDGE_ONLY, PIO_EDGE_LEVEL} pio_trig_t;

    // drive of one bidirectional port: level and output enable per pin
    typedef struct packed {
        logic [PORT_W-1:0] level;
        logic [PORT_W-1:0] enable;
    } pio_drive_t;

    // enable and channel bits taken from the converter control register
    typedef struct packed {
        logic enable;
        logic [CHAN_W-1:0] chan;
    } pio_adc_t;

endpackage

/* hw/pio_port.sv */
// one bidirectional port: output latch, direction bits, read-back mux
// assumes: pin levels arrive already synchronised; strobes last one cycle
`timescale 1ns/1ns
module pio_port #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register writes
    input wire logic [WIDTH-1:0] wrData,
    input wire logic wrLatch,
    input wire logic wrDir,
    // pin side
    input wire logic [WIDTH-1:0] pinLevel,
    output logic [WIDTH-1:0] latchQ,
    output logic [WIDTH-1:0] dirQ,
    // value software sees
    output logic [WIDTH-1:0] readBack
);
    import pio_pkg::*;

    // helper for the latch check: latch holds a written value
    logic latchValid;

    // output latch has no reset on purpose, it keeps its contents
    // latch untouched by reset
    always_ff @(posedge ref_clk)
    begin
        if (wrLatch)
        begin
            latchQ <= wrData;
        end
    end

    // direction bits, one enables the driver
    // directions cleared on reset
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dirQ <= {WIDTH{DIR_RESET_BIT}};
        end
        else if (wrDir)
        begin
            dirQ <= wrData;
        end
    end

    // outputs read the latch, inputs read the pin
    // output bits read latch
    assign readBack = (dirQ & latchQ) | (~dirQ & pinLevel);

    // assertion helper only
    always_ff @(posedge ref_clk)
    begin
        if (wrLatch)
        begin
            latchValid <= 1'b1;
        end
        else if (rst)
        begin
            latchValid <= 1'b0;
        end
    end

    dir_reset_a: assert property (@(posedge ref_clk) rst |=> dirQ == '0)
        else $error("direction bits not cleared by reset");

    latch_write_a: assert property (@(posedge ref_clk) wrLatch |=> latchQ == $past(wrData))
        else $error("latch did not take written data");

    latch_keep_a: assert property (@(posedge ref_clk)
        (latchValid && rst && !wrLatch) |=> latchQ == $past(latchQ))
        else $error("reset disturbed the output latch");

endmodule

/* hw/pio_sync.sv */
// two-stage synchroniser for a group of asynchronous pin levels
// assumes: inputs change without relation to ref_clk; reset is synchronous
`timescale 1ns/1ns
module pio_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // raw pins and synchronised result
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);

    // first stage; only the second stage may look at it
    logic [WIDTH-1:0] meta;

    // two flops in a row, nothing taps the first
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            meta <= RESET_VAL;
            synced <= RESET_VAL;
        end
        else
        begin
            meta <= async;
            synced <= meta;
        end
    end

endmodule

/* hw/pio_top.sv */
// parallel i/o ports: two 8-bit bidirectional ports, one 4-bit input port
// assumes: apb master on ref_clk, pins and reset/irq pins asynchronous,
// converter control bits come from the converter on the same clock
//
// How it works
// - two 8-bit bidirectional ports, one 4-bit input port
// - direction one drives pin, zero makes input
// - every reset clears all direction bits
// - reset leaves output data latches unchanged
// - port data at indexes zero, one, three
// - output pins read back latch value
// - input pins read back pin level
// - writes always reach latch; drives when output
// - channel bits pick analog pin when enabled
// - selected analog channel reads zero when enabled
// - unselected input pins still read true levels
// - converter off: all four read pin levels
// - any reset turns converter use off
// - low reset pin forces start-up state
// - interrupt pin: falling edge, optionally low level
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
module pio_top #(
    parameter pio_pkg::pio_trig_t TRIG_MODE = pio_pkg::PIO_EDGE_LEVEL
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pio_pkg::ADDR_W-1:0] paddr,
    input wire logic [pio_pkg::DATA_W-1:0] pwdata,
    output logic [pio_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter control bits
    input wire pio_pkg::pio_adc_t adcCtrl,
    output logic [pio_pkg::IN_W-1:0] analogSwitch,
    // first bidirectional port
    input wire logic [pio_pkg::PORT_W-1:0] firstPortPinsIn,
    output pio_pkg::pio_drive_t firstPortPinsDrive,
    // second bidirectional port
    input wire logic [pio_pkg::PORT_W-1:0] secondPortPinsIn,
    output pio_pkg::pio_drive_t secondPortPinsDrive,
    // input-only port shared with analog inputs
    input wire logic [pio_pkg::IN_W-1:0] inputOnlyAnalogPins,
    // reset pin and interrupt pin
    input wire logic resetPin_n,
    input wire logic irqPin_n,
    input wire logic irqAck,
    output logic irqRequest,
    output logic deviceReset
);
    import pio_pkg::*;

    // synchronised pin levels
    logic [PORT_W-1:0] firstSync;
    logic [PORT_W-1:0] secondSync;
    logic [IN_W-1:0] inputSync;
    logic [1:0] ctrlSync;

    // internal reset and the converter bits as this block sees them
    logic rst;
    pio_adc_t adcLive;

    // port module outputs
    logic [PORT_W-1:0] firstLatch;
    logic [PORT_W-1:0] firstDir;
    logic [PORT_W-1:0] firstRead;
    logic [PORT_W-1:0] secondLatch;
    logic [PORT_W-1:0] secondDir;
    logic [PORT_W-1:0] secondRead;

    // interrupt state
    logic irqPrev;
    logic irqPending;

    pio_sync #(
        .WIDTH(PORT_W),
        .RESET_VAL('0)
    ) u_sync_first (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async(firstPortPinsIn),
        .synced(firstSync)
    );

    // second port pins
    pio_sync #(
        .WIDTH(PORT_W),
        .RESET_VAL('0)
    ) u_sync_second (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async(secondPortPinsIn),
        .synced(secondSync)
    );

    // input-only pins
    pio_sync #(
        .WIDTH(IN_W),
        .RESET_VAL('0)
    ) u_sync_input (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async(inputOnlyAnalogPins),
        .synced(inputSync)
    );

    // reset and interrupt pins idle high; only sys_rst resets these,
    // otherwise the pin reset would hold itself forever
    pio_sync #(
        .WIDTH(2),
        .RESET_VAL({PIN_IDLE_HIGH, PIN_IDLE_HIGH})
    ) u_sync_ctrl (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async({irqPin_n, resetPin_n}),
        .synced(ctrlSync)
    );

    // named views of the control pins
    wire resetPinLevel = ctrlSync[0];
    wire irqLevel = ctrlSync[1];

    // low reset pin joins the reset
    assign rst = sys_rst | ~resetPinLevel;

    // reset seen by the rest of the chip, from a flop
    always_ff @(posedge ref_clk)
    begin
        deviceReset <= rst;
    end

    // apb phases
    wire setupPhase = psel & ~penable;
    wire accessPhase = psel & penable;

    // address decode; misaligned or high addresses hit nothing
    // data registers at indexes 0, 1, 3
    wire [2:0] regIdx = paddr[IDX_MSB:IDX_LSB];
    wire alignedOk = (paddr[IDX_LSB-1:0] == '0) && (paddr[ADDR_W-1:IDX_MSB+1] == '0);
    wire hitFirstData = alignedOk && (regIdx == IDX_FIRST_DATA);
    wire hitSecondData = alignedOk && (regIdx == IDX_SECOND_DATA);
    wire hitInputData = alignedOk && (regIdx == IDX_INPUT_DATA);
    wire hitFirstDir = alignedOk && (regIdx == IDX_FIRST_DIR);
    wire hitSecondDir = alignedOk && (regIdx == IDX_SECOND_DIR);
    wire mapped = hitFirstData | hitSecondData | hitInputData | hitFirstDir | hitSecondDir;

    // write strobes, one cycle in the access phase
    // writes to the input-only port are accepted and dropped
    wire writeStrobe = accessPhase & pwrite;
    wire wrFirstData = writeStrobe & hitFirstData;
    wire wrSecondData = writeStrobe & hitSecondData;
    wire wrFirstDir = writeStrobe & hitFirstDir;
    wire wrSecondDir = writeStrobe & hitSecondDir;
    wire [PORT_W-1:0] wrByte = pwdata[PORT_W-1:0];

    // zero wait states; unmapped addresses end in an error
    assign pready = 1'b1;
    assign pslverr = accessPhase & ~mapped;

    // first port: latch, direction and read-back
    pio_port #(
        .WIDTH(PORT_W)
    ) u_port_first (
        .ref_clk(ref_clk),
        .rst(rst),
        .wrData(wrByte),
        .wrLatch(wrFirstData),
        .wrDir(wrFirstDir),
        .pinLevel(firstSync),
        .latchQ(firstLatch),
        .dirQ(firstDir),
        .readBack(firstRead)
    );

    // second port
    pio_port #(
        .WIDTH(PORT_W)
    ) u_port_second (
        .ref_clk(ref_clk),
        .rst(rst),
        .wrData(wrByte),
        .wrLatch(wrSecondData),
        .wrDir(wrSecondDir),
        .pinLevel(secondSync),
        .latchQ(secondLatch),
        .dirQ(secondDir),
        .readBack(secondRead)
    );

    // driver enabled only by a set direction bit
    assign firstPortPinsDrive.level = firstLatch;
    assign firstPortPinsDrive.enable = firstDir;
    assign secondPortPinsDrive.level = secondLatch;
    assign secondPortPinsDrive.enable = secondDir;

    // converter bits, forced off by any reset
    // reset disables converter use
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            adcLive <= '0;
        end
        else
        begin
            adcLive <= adcCtrl;
        end
    end

    // selected channel, empty while the converter is off
    // channel bits choose analog pin
    wire [IN_W-1:0] chanOneHot = ONE_HOT_BASE << adcLive.chan;
    wire [IN_W-1:0] analogMask = adcLive.enable ? chanOneHot : '0;

    wire [IN_W-1:0] inputRead = inputSync & ~analogMask;

    // analog switch for the converter, from a flop
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            analogSwitch <= '0;
        end
        else
        begin
            analogSwitch <= analogMask;
        end
    end

    // read mux; bits above the register width read zero
    wire [DATA_W-1:0] next_rdata =
        hitFirstData ? {{(DATA_W-PORT_W){1'b0}}, firstRead} :
        hitSecondData ? {{(DATA_W-PORT_W){1'b0}}, secondRead} :
        hitInputData ? {{(DATA_W-IN_W){1'b0}}, inputRead} :
        hitFirstDir ? {{(DATA_W-PORT_W){1'b0}}, firstDir} :
        hitSecondDir ? {{(DATA_W-PORT_W){1'b0}}, secondDir} :
        RDATA_RESET;

    // read data taken in the setup cycle, shown in the access cycle;
    // a pin that moves between the two is seen at its setup value
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            prdata <= RDATA_RESET;
        end
        else if (setupPhase && !pwrite)
        begin
            prdata <= next_rdata;
        end
    end

    // falling edge seen on the synchronised level
    wire irqFall = irqPrev & ~irqLevel;

    // edge memory and pending flag; a new edge wins over an acknowledge
    // falling edge latches request
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            irqPrev <= PIN_IDLE_HIGH;
            irqPending <= 1'b0;
        end
        else
        begin
            irqPrev <= irqLevel;
            if (irqFall)
            begin
                irqPending <= 1'b1;
            end
            else if (irqAck)
            begin
                irqPending <= 1'b0;
            end
        end
    end

    // level option keeps asking while the pin stays low
    // optional low-level trigger
    wire levelTrig = (TRIG_MODE == PIO_EDGE_LEVEL) && !irqLevel;
    assign irqRequest = irqPending | levelTrig;

    default clocking cb @(posedge ref_clk);
    endclocking

    out_enable_a: assert property (disable iff (rst) wrFirstDir |=>
        firstPortPinsDrive.enable == $past(wrByte))
        else $error("driver enable does not follow direction write");

    pin_reset_a: assert property (disable iff (sys_rst) !resetPinLevel |=>
        (firstDir == '0) && (secondDir == '0) && !adcLive.enable && deviceReset)
        else $error("reset pin did not force start-up state");

    read_latch_a: assert property (disable iff (rst) (setupPhase && !pwrite && hitFirstData) |=>
        (prdata[PORT_W-1:0] & $past(firstDir)) == ($past(firstLatch) & $past(firstDir)))
        else $error("output bit did not read the latch");

    read_pin_a: assert property (disable iff (rst) (setupPhase && !pwrite && hitSecondData) |=>
        (prdata[PORT_W-1:0] & ~$past(secondDir)) == ($past(secondSync) & ~$past(secondDir)))
        else $error("input bit did not read the pin");

    addr_decode_a: assert property (disable iff (rst) (setupPhase && !pwrite && hitInputData) |=>
        (prdata[DATA_W-1:IN_W] == '0) && !pslverr)
        else $error("input port read gave high bits or error");

    adc_mask_a: assert property (disable iff (rst)
        (setupPhase && !pwrite && hitInputData && adcLive.enable) |=>
        prdata[$past(adcLive.chan)] == 1'b0)
        else $error("selected analog channel did not read zero");

    adc_pass_a: assert property (disable iff (rst) (setupPhase && !pwrite && hitInputData) |=>
        prdata[IN_W-1:0] == ($past(inputSync) & ~$past(analogMask)))
        else $error("unselected input bits wrong");

    adc_reset_a: assert property (rst |=> !adcLive.enable ##1 analogSwitch == '0)
        else $error("reset did not turn the converter use off");

    sync_delay_a: assert property (disable iff (sys_rst)
        (!$past(sys_rst) && !$past(sys_rst, 2)) |-> firstSync == $past(firstPortPinsIn, 2))
        else $error("pin level not delayed by two flops");

    irq_edge_a: assert property (disable iff (rst) irqFall |=>
        irqRequest ##1 (irqRequest || $past(irqAck)))
        else $error("falling edge did not raise request");

    unmapped_err_a: assert property (disable iff (rst) (accessPhase && !mapped) |->
        pslverr && pready)
        else $error("unmapped access not answered with error");

    write_first_c: cover property (disable iff (rst) wrFirstData ##1 wrFirstDir);
    adc_read_c: cover property (disable iff (rst) setupPhase && hitInputData && adcLive.enable);
    irq_edge_c: cover property (disable iff (rst) irqFall ##[1:8] irqAck);
    unmapped_c: cover property (disable iff (rst) accessPhase && !mapped);

endmodule

/* test/pio_pin_model.sv */
// outside circuit on the two bidirectional ports: resolves each wire
// assumes: bench sets what the outside drives and which pins are overloaded
`timescale 1ns/1ns
module pio_pin_model
(
    // what the device drives
    input wire pio_pkg::pio_drive_t firstDrive,
    input wire pio_pkg::pio_drive_t secondDrive,
    // what the outside circuit does
    input wire logic [pio_pkg::PORT_W-1:0] firstExt,
    input wire logic [pio_pkg::PORT_W-1:0] secondExt,
    input wire logic [pio_pkg::PORT_W-1:0] heavyLoad,
    // resolved wire levels
    output logic [pio_pkg::PORT_W-1:0] firstWire,
    output logic [pio_pkg::PORT_W-1:0] secondWire
);
    import pio_pkg::*;

    // driven pins follow the latch unless a stiff load drags them low;
    // without that a latch read-back could not be told from a pin read
    assign firstWire = (firstDrive.enable & firstDrive.level & ~heavyLoad)
        | (~firstDrive.enable & firstExt);
    // undriven pins take whatever the outside circuit puts there
    assign secondWire = (secondDrive.enable & secondDrive.level & ~heavyLoad)
        | (~secondDrive.enable & secondExt);
endmodule

/* test/testbench.sv */
// self-checking bench for the parallel i/o ports over apb
// assumes: default edge-plus-level interrupt option, 20 MHz ref_clk
`timescale 1ns/1ns
module testbench;
    import pio_pkg::*;
    // clock, reset and apb
    logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic err;
    // pins and side bands
    pio_adc_t adcCtrl;
    pio_drive_t firstDrive, secondDrive;
    logic [PORT_W-1:0] firstExt, secondExt, heavyLoad, firstWire, secondWire;
    logic [IN_W-1:0] analogSwitch, inPins;
    logic resetPin_n, irqPin_n, irqAck, irqRequest, deviceReset;
    // request of the edge-only build, watched beside the default one
    logic edgeIrq;
    int n_mismatch, n_compared;

    pio_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adcCtrl(adcCtrl), .analogSwitch(analogSwitch),
        .firstPortPinsIn(firstWire), .firstPortPinsDrive(firstDrive),
        .secondPortPinsIn(secondWire), .secondPortPinsDrive(secondDrive),
        .inputOnlyAnalogPins(inPins), .resetPin_n(resetPin_n), .irqPin_n(irqPin_n),
        .irqAck(irqAck), .irqRequest(irqRequest), .deviceReset(deviceReset));

    pio_pin_model pins (.firstDrive(firstDrive), .secondDrive(secondDrive),
        .firstExt(firstExt), .secondExt(secondExt), .heavyLoad(heavyLoad),
        .firstWire(firstWire), .secondWire(secondWire));

    // edge-only interrupt option on the same pins and bus
    pio_top #(.TRIG_MODE(PIO_EDGE_ONLY)) dut_edge (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(), .pready(), .pslverr(), .adcCtrl(adcCtrl), .analogSwitch(),
        .firstPortPinsIn(firstWire), .firstPortPinsDrive(),
        .secondPortPinsIn(secondWire), .secondPortPinsDrive(),
        .inputOnlyAnalogPins(inPins), .resetPin_n(resetPin_n), .irqPin_n(irqPin_n),
        .irqAck(irqAck), .irqRequest(edgeIrq), .deviceReset());

    // 50 ns clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // verdict in one place
    task automatic summarize();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // value compare with four-state equality
    task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; entered just after a rising edge, leaves one idle edge
    task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        // wait for pready, bounded so a dead slave cannot hang us
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            checkVal("pready", 32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    // read and compare data and error flag
    task automatic apbCheck(input string what, input logic [7:0] a, input logic [31:0] exp,
        input logic expErr);
        apbXfer(1'b0, a, 32'h0);
        checkVal(what, exp, rd);
        checkVal("pslverr", {31'h0, expErr}, {31'h0, err});
    endtask

    task automatic waitEdges(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // watchdog: the whole sequence needs well under 5000 cycles
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        summarize();
    end

    initial
    begin
        n_mismatch = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        {psel, penable, pwrite, irqAck} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        adcCtrl = '0;
        firstExt = 8'ha5;
        secondExt = 8'h3c;
        heavyLoad = 8'h00;
        inPins = 4'hf;
        resetPin_n = 1'b1;
        irqPin_n = 1'b1;
        waitEdges(6);
        sys_rst <= 1'b0;
        waitEdges(1);
        apbCheck("first dir", 8'h10, 32'h0, 1'b0);
        apbCheck("second dir", 8'h14, 32'h0, 1'b0);
        checkVal("first enable", 32'h0, {24'h0, firstDrive.enable});
        // input pins read the wire level
        apbCheck("first pins", 8'h00, 32'ha5, 1'b0);
        apbCheck("second pins", 8'h04, 32'h3c, 1'b0);
        // latches loaded before any direction bit is set
        apbXfer(1'b1, 8'h00, 32'h5a);
        apbXfer(1'b1, 8'h04, 32'hc3);
        checkVal("first latch", 32'h5a, {24'h0, firstDrive.level});
        checkVal("first enable", 32'h0, {24'h0, firstDrive.enable});
        apbCheck("first still pins", 8'h00, 32'ha5, 1'b0);
        // overloaded output pins still read the latch
        heavyLoad <= 8'hff;
        apbXfer(1'b1, 8'h10, 32'h0f);
        apbXfer(1'b1, 8'h14, 32'hf0);
        waitEdges(3);
        checkVal("first enable", 32'h0f, {24'h0, firstDrive.enable});
        checkVal("second enable", 32'hf0, {24'h0, secondDrive.enable});
        apbCheck("first mixed", 8'h00, 32'haa, 1'b0);
        apbCheck("second mixed", 8'h04, 32'hcc, 1'b0);
        apbCheck("unmapped", 8'h08, 32'h0, 1'b1);
        sys_rst <= 1'b1;
        adcCtrl <= '{enable: 1'b1, chan: 2'h2};
        waitEdges(4);
        checkVal("switch in reset", 32'h0, {28'h0, analogSwitch});
        sys_rst <= 1'b0;
        adcCtrl <= '0;
        waitEdges(1);
        checkVal("first latch kept", 32'h5a, {24'h0, firstDrive.level});
        checkVal("second latch kept", 32'hc3, {24'h0, secondDrive.level});
        apbCheck("first dir", 8'h10, 32'h0, 1'b0);
        // reset pin low gives the start-up state
        apbXfer(1'b1, 8'h10, 32'hff);
        resetPin_n <= 1'b0;
        waitEdges(4);
        checkVal("device reset", 32'h1, {31'h0, deviceReset});
        checkVal("first enable", 32'h0, {24'h0, firstDrive.enable});
        resetPin_n <= 1'b1;
        waitEdges(4);
        inPins <= 4'hb;
        waitEdges(4);
        apbCheck("input port", 8'h0c, 32'hb, 1'b0);
        for (int c = 0; c < 4; c++)
        begin
            inPins <= 4'hf;
            adcCtrl <= '{enable: 1'b1, chan: c[1:0]};
            waitEdges(4);
            checkVal("switch", 32'h1 << c, {28'h0, analogSwitch});
            apbCheck("input adc", 8'h0c, 32'hf & ~(32'h1 << c), 1'b0);
        end
        adcCtrl <= '0;
        waitEdges(4);
        apbCheck("input off", 8'h0c, 32'hf, 1'b0);
        // falling edge, then level holds over an ack
        irqPin_n <= 1'b0;
        waitEdges(4);
        checkVal("irq edge", 32'h1, {31'h0, irqRequest});
        checkVal("edge-only irq", 32'h1, {31'h0, edgeIrq});
        irqAck <= 1'b1;
        waitEdges(1);
        irqAck <= 1'b0;
        waitEdges(1);
        checkVal("irq level", 32'h1, {31'h0, irqRequest});
        checkVal("edge-only acked", 32'h0, {31'h0, edgeIrq});
        irqPin_n <= 1'b1;
        waitEdges(4);
        irqAck <= 1'b1;
        waitEdges(1);
        irqAck <= 1'b0;
        waitEdges(1);
        checkVal("irq cleared", 32'h0, {31'h0, irqRequest});
        summarize();
    end
endmodule
